// *** core/lmmx_pkg.sv ***
package lmmx_pkg;

    // Opcode patterns on the upper byte of the instruction word
    localparam logic [7:0] LMMX_OP_LOAD_LIT = 8'h0E;  // 0000 1110 kkkk kkkk
    localparam logic [7:0] LMMX_OP_MUL_LIT = 8'h0D;   // 0000 1101 kkkk kkkk
    localparam logic [6:0] LMMX_OP_STORE = 7'h37;     // 0110 111a ffff ffff
    localparam logic [6:0] LMMX_OP_MUL_FILE = 7'h01;  // 0000 001a ffff ffff

    // Highest file address that switches to indexed literal offset mode
    localparam logic [7:0] LMMX_INDEXED_MAX = 8'h5F;

    // Reset values
    localparam logic [7:0] LMMX_ACC_RESET = 8'h00;
    localparam logic [7:0] LMMX_PROD_RESET = 8'h00;

    // Quarter phase of the instruction cycle, one-hot
    typedef enum logic [3:0] {
        LMMX_Q1 = 4'h1,
        LMMX_Q2 = 4'h2,
        LMMX_Q3 = 4'h4,
        LMMX_Q4 = 4'h8
    } lmmx_phase_t;

    // Instruction class found by the decoder
    typedef enum logic [4:0] {
        LMMX_K_NONE = 5'h01,
        LMMX_K_LOAD_LIT = 5'h02,
        LMMX_K_STORE = 5'h04,
        LMMX_K_MUL_LIT = 5'h08,
        LMMX_K_MUL_FILE = 5'h10
    } lmmx_kind_t;

    // Data memory addressing mode
    typedef enum logic [2:0] {
        LMMX_AM_ACCESS = 3'h1,
        LMMX_AM_BANKED = 3'h2,
        LMMX_AM_INDEXED = 3'h4
    } lmmx_amode_t;

    // Decoded instruction carried through the cycle
    typedef struct packed {
        lmmx_kind_t kind;
        lmmx_amode_t amode;
        logic [7:0] operand;
    } lmmx_decode_t;

    // Request toward the data memory
    typedef struct packed {
        logic rd;
        logic wr;
        lmmx_amode_t amode;
        logic [3:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lmmx_mem_req_t;

endpackage

// *** core/lmmx_decoder.sv ***
`timescale 1ns/1ps
module lmmx_decoder
    import lmmx_pkg::*;
(
    input wire logic [15:0] instr,
    input wire logic ext_enable,
    output lmmx_decode_t dec
);

    logic access_bit; // Bank-access bit of register-operand forms
    assign access_bit = instr[8];

    // Decode opcode, then pick addressing mode for file operands
    always_comb begin
        dec.kind = LMMX_K_NONE;
        dec.operand = instr[7:0];
        if (instr[15:8] == LMMX_OP_LOAD_LIT) begin
            dec.kind = LMMX_K_LOAD_LIT;
        end else if (instr[15:8] == LMMX_OP_MUL_LIT) begin
            dec.kind = LMMX_K_MUL_LIT;
        end else if (instr[15:9] == LMMX_OP_STORE) begin
            dec.kind = LMMX_K_STORE;
        end else if (instr[15:9] == LMMX_OP_MUL_FILE) begin
            dec.kind = LMMX_K_MUL_FILE;
        end
        // Access bit, extended set and a low address pick the mode
        if (access_bit) begin
            dec.amode = LMMX_AM_BANKED;
        end else if (ext_enable && instr[7:0] <= LMMX_INDEXED_MAX) begin
            dec.amode = LMMX_AM_INDEXED;
        end else begin
            dec.amode = LMMX_AM_ACCESS;
        end
    end

endmodule

// *** core/lmmx_exec.sv ***
`timescale 1ns/1ps
// Behaviour
// - Load literal opcode puts literal into accumulator
// - Store opcode copies accumulator to file
// - File address reaches all of 256-byte bank
// - Access bit picks access bank or banked
// - Extended set, clear bit, low address: indexed
// - Literal multiply opcode, unsigned accumulator times literal
// - File multiply opcode, unsigned accumulator times file
// - Product high and low bytes written
// - Multiplies leave accumulator and file unchanged
// - Multiplies touch no status flag
// - No overflow or carry for products
module lmmx_exec
    import lmmx_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [15:0] INSTR,
    input wire logic EXT_ENABLE,
    input wire logic [3:0] BANK_SELECT,
    input wire logic [7:0] MEM_RDATA,
    output lmmx_mem_req_t MEM_REQ,
    output logic [7:0] ACC,
    output logic [7:0] PRODUCT_HIGH_BYTE,
    output logic [7:0] PRODUCT_LOW_BYTE,
    output logic [3:0] PHASE,
    output logic DONE
);

    lmmx_phase_t phase; // Current quarter
    lmmx_phase_t next_phase;
    lmmx_decode_t dec_now; // Combinational decode of INSTR
    lmmx_decode_t held; // Decode captured in Q1
    lmmx_decode_t next_held;
    logic [7:0] operand; // Literal or file value read in Q2
    logic [7:0] next_operand;
    logic [15:0] result; // Product formed in Q3
    logic [15:0] next_result;
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic [7:0] prod_hi;
    logic [7:0] next_prod_hi;
    logic [7:0] prod_lo;
    logic [7:0] next_prod_lo;
    lmmx_mem_req_t mem;
    lmmx_mem_req_t next_mem;
    logic done;
    logic next_done;

    // Opcode and address mode decoder
    lmmx_decoder u_dec (
        .instr(INSTR),
        .ext_enable(EXT_ENABLE),
        .dec(dec_now)
    );

    // Quarter sequencer: four phases per instruction
    always_comb begin
        case (phase)
            LMMX_Q1: next_phase = LMMX_Q2;
            LMMX_Q2: next_phase = LMMX_Q3;
            LMMX_Q3: next_phase = LMMX_Q4;
            LMMX_Q4: next_phase = LMMX_Q1;
            default: next_phase = LMMX_Q1;
        endcase
    end

    // Datapath next values, one step per quarter
    // The file read goes out at the end of Q1 so that its data is
    // settled on the read bus before the edge that leaves Q2
    always_comb begin
        next_held = held;
        next_operand = operand;
        next_result = result;
        next_acc = acc;
        next_prod_hi = prod_hi;
        next_prod_lo = prod_lo;
        // Read and write strobes drop unless a quarter raises them
        next_mem = '0;
        next_mem.amode = held.amode;
        next_mem.bank = BANK_SELECT;
        next_mem.addr = held.operand;
        next_done = 1'b0;
        case (phase)
            // Decode: latch instruction
            LMMX_Q1: begin
                next_held = dec_now;
                next_mem.amode = dec_now.amode;
                next_mem.addr = dec_now.operand;
                // Issue file read so data is back by Q3
                next_mem.rd = (dec_now.kind == LMMX_K_MUL_FILE);
            end
            // Read: literal from instruction, or file value
            LMMX_Q2: begin
                if (held.kind == LMMX_K_MUL_FILE) begin
                    next_operand = MEM_RDATA;
                end else begin
                    next_operand = held.operand;
                end
            end
            // Process: unsigned 8x8 always fits 16 bits, so no carry out
            LMMX_Q3: begin
                next_result = {8'h00, acc} * {8'h00, operand};
                if (held.kind == LMMX_K_STORE) begin
                    next_mem.wr = 1'b1;
                    next_mem.wdata = acc;
                end
            end
            // Write destination; this block keeps no status flags
            LMMX_Q4: begin
                next_done = 1'b1;
                case (held.kind)
                    LMMX_K_LOAD_LIT: next_acc = operand;
                    LMMX_K_MUL_LIT, LMMX_K_MUL_FILE: begin
                        next_prod_hi = result[15:8];
                        next_prod_lo = result[7:0];
                    end
                    default: next_acc = acc;
                endcase
            end
            default: next_held = held;
        endcase
    end

    // Register all state
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            phase <= LMMX_Q1;
            held <= '{kind: LMMX_K_NONE, amode: LMMX_AM_ACCESS, operand: 8'h00};
            operand <= 8'h00;
            result <= 16'h0000;
            acc <= LMMX_ACC_RESET;
            prod_hi <= LMMX_PROD_RESET;
            prod_lo <= LMMX_PROD_RESET;
            mem <= '0;
            done <= 1'b0;
        end else begin
            phase <= next_phase;
            held <= next_held;
            operand <= next_operand;
            result <= next_result;
            acc <= next_acc;
            prod_hi <= next_prod_hi;
            prod_lo <= next_prod_lo;
            mem <= next_mem;
            done <= next_done;
        end
    end

    // Outputs come straight from the registers above
    assign MEM_REQ = mem;
    assign ACC = acc;
    assign PRODUCT_HIGH_BYTE = prod_hi;
    assign PRODUCT_LOW_BYTE = prod_lo;
    assign PHASE = phase;
    assign DONE = done;

    // Assertions
    mul_acc_kept_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q4 && (held.kind == LMMX_K_MUL_LIT || held.kind == LMMX_K_MUL_FILE))
        |=> acc == $past(acc))
        else $error("multiply changed accumulator");
    mul_no_write_a: assert property (@(posedge CLOCK) disable iff (SRST)
        mem.wr |-> held.kind == LMMX_K_STORE)
        else $error("memory write outside store");
    prod_value_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q2 && (held.kind == LMMX_K_MUL_LIT || held.kind == LMMX_K_MUL_FILE))
        |=> ##2 {prod_hi, prod_lo} == $past(acc, 3) * $past(operand, 2))
        else $error("product pair wrong");
    load_value_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q1 && dec_now.kind == LMMX_K_LOAD_LIT)
        |=> ##3 acc == $past(INSTR[7:0], 4))
        else $error("literal not loaded");
    store_write_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q3 && held.kind == LMMX_K_STORE)
        |=> mem.wr && mem.wdata == $past(acc) && mem.addr == held.operand)
        else $error("store write wrong");
    phase_ring_a: assert property (@(posedge CLOCK) disable iff (SRST)
        phase == LMMX_Q1 |=> phase == LMMX_Q2 ##1 phase == LMMX_Q3 ##1 phase == LMMX_Q4)
        else $error("quarter sequence broken");
    done_q4_a: assert property (@(posedge CLOCK) disable iff (SRST)
        done |-> phase == LMMX_Q1 && $past(phase) == LMMX_Q4)
        else $error("done out of step");
    indexed_mode_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q1 && !INSTR[8] && EXT_ENABLE && INSTR[7:0] <= LMMX_INDEXED_MAX)
        |=> held.amode == LMMX_AM_INDEXED)
        else $error("indexed mode missed");
    banked_mode_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q1 && INSTR[8]) |=> held.amode == LMMX_AM_BANKED)
        else $error("banked mode missed");
    load_prod_kept_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q4 && held.kind == LMMX_K_LOAD_LIT) |=> $stable(prod_lo))
        else $error("load touched product");

    // Read path, operand capture, request, address mode, store and retire checks
    read_q2_a: assert property (@(posedge CLOCK) disable iff (SRST)
        mem.rd |-> phase == LMMX_Q2 && held.kind == LMMX_K_MUL_FILE)
        else $error("file read out of step");
    file_operand_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q2 && held.kind == LMMX_K_MUL_FILE) |=> operand == $past(MEM_RDATA))
        else $error("file operand not captured");
    lit_operand_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q2 && held.kind == LMMX_K_MUL_LIT) |=> operand == held.operand)
        else $error("literal operand not captured");
    access_mode_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q1 && !INSTR[8] && !(EXT_ENABLE && INSTR[7:0] <= LMMX_INDEXED_MAX))
        |=> held.amode == LMMX_AM_ACCESS)
        else $error("access bank mode missed");
    req_bank_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (mem.rd || mem.wr) |-> mem.bank == $past(BANK_SELECT))
        else $error("request bank wrong");
    store_kept_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (phase == LMMX_Q4 && held.kind == LMMX_K_STORE)
        |=> $stable(acc) && $stable(prod_hi) && $stable(prod_lo))
        else $error("store touched registers");
    done_pulse_a: assert property (@(posedge CLOCK) disable iff (SRST)
        done |=> !done)
        else $error("retire pulse too long");

    // Main scenarios worth seeing in a run
    cover_load_c: cover property (@(posedge CLOCK) done && $past(held.kind) == LMMX_K_LOAD_LIT);
    cover_indexed_c: cover property (@(posedge CLOCK) mem.wr && mem.amode == LMMX_AM_INDEXED);
    cover_store_c: cover property (@(posedge CLOCK) mem.wr);
    cover_mul_file_c: cover property (@(posedge CLOCK) done && held.kind == LMMX_K_MUL_FILE);
    cover_zero_c: cover property (@(posedge CLOCK) done && prod_hi == 8'h00 && prod_lo == 8'h00
        && held.kind == LMMX_K_MUL_LIT);

endmodule

// *** testbench/tb_literal_move_multiply_exec.sv ***
`timescale 1ns/1ps
module tb_literal_move_multiply_exec
    import lmmx_pkg::*;
;
    logic clock; // Bench clock, 50 ns period
    logic srst; // Synchronous reset, active high
    logic [15:0] instr; // Instruction word toward the decoder
    logic ext_enable; // Extended set enable
    logic [3:0] bank_select; // Bank select value
    logic [7:0] mem_rdata; // File read data
    lmmx_mem_req_t mem_req; // Memory request from the block
    logic [7:0] acc; // Accumulator
    logic [7:0] prod_hi; // Product high byte
    logic [7:0] prod_lo; // Product low byte
    logic [3:0] phase; // Quarter phase
    logic done; // Retire pulse
    int mismatches; // Count of failed comparisons
    int checks_done; // Count of comparisons
    int cycles; // Cycle count for the hang guard
    int acc_m; // Model accumulator
    int prod_m; // Model product pair
    logic [15:0] tab [12] = '{16'h0E5A, 16'h6E5F, 16'h6E60, 16'h6E00, 16'h6FFF, 16'h0EE2,
        16'h0DC4, 16'h0EC4, 16'h03A7, 16'h0210, 16'h0D00, 16'h0F00}; // Directed cases
    logic tab_ext [12] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
        1'b0, 1'b0}; // Extended set per case

    lmmx_exec dut (.CLOCK(clock), .SRST(srst), .INSTR(instr), .EXT_ENABLE(ext_enable),
        .BANK_SELECT(bank_select), .MEM_RDATA(mem_rdata), .MEM_REQ(mem_req), .ACC(acc),
        .PRODUCT_HIGH_BYTE(prod_hi), .PRODUCT_LOW_BYTE(prod_lo), .PHASE(phase), .DONE(done));

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Prints the counts and the verdict, then stops
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Hang guard: a stuck run counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // Runs one instruction through its four quarters and checks every result
    task automatic run_op(input logic [15:0] ins, input logic ext, input logic [7:0] rdv);
        int n;
        logic is_ld, is_st, is_ml, is_mf;
        logic [2:0] am;
        n = 0;
        while (phase !== LMMX_Q1 && n < 8) begin
            @(posedge clock);
            #2;
            n++;
        end
        instr = ins;
        ext_enable = ext;
        bank_select = 4'($urandom);
        is_ld = (ins[15:8] == LMMX_OP_LOAD_LIT);
        is_ml = (ins[15:8] == LMMX_OP_MUL_LIT);
        is_st = (ins[15:9] == LMMX_OP_STORE);
        is_mf = (ins[15:9] == LMMX_OP_MUL_FILE);
        // Banked when the bit is set, indexed for low addresses with the extended set
        am = ins[8] ? LMMX_AM_BANKED :
            ((ext && ins[7:0] <= LMMX_INDEXED_MAX) ? LMMX_AM_INDEXED : LMMX_AM_ACCESS);
        @(posedge clock);
        #2;
        check("phase Q2", 16'(phase), 16'(LMMX_Q2));
        check("rd in Q2", 16'(mem_req.rd), 16'(is_mf));
        if (is_mf) begin
            check("rd addr", 16'(mem_req.addr), 16'(ins[7:0]));
            check("rd amode", 16'(mem_req.amode), 16'(am));
            check("rd bank", 16'(mem_req.bank), 16'(bank_select));
        end
        mem_rdata = rdv;
        @(posedge clock);
        #2;
        mem_rdata = ~rdv;
        @(posedge clock);
        #2;
        check("phase Q4", 16'(phase), 16'(LMMX_Q4));
        check("done in Q4", 16'(done), 16'h0000);
        check("wr in Q4", 16'(mem_req.wr), 16'(is_st));
        if (is_st) begin
            check("wr data", 16'(mem_req.wdata), 16'(acc_m[7:0]));
            check("wr addr", 16'(mem_req.addr), 16'(ins[7:0]));
            check("wr amode", 16'(mem_req.amode), 16'(am));
            check("wr bank", 16'(mem_req.bank), 16'(bank_select));
        end
        if (is_ld) acc_m = ins[7:0];
        if (is_ml) prod_m = acc_m * ins[7:0];
        if (is_mf) prod_m = acc_m * rdv;
        @(posedge clock);
        #2;
        check("done", 16'(done), 16'h0001);
        check("acc", 16'(acc), 16'(acc_m));
        check("product high", 16'(prod_hi), 16'(prod_m[15:8]));
        check("product low", 16'(prod_lo), 16'(prod_m[7:0]));
    endtask

    // Main sequence
    initial begin
        logic [7:0] hi;
        srst = 1'b1;
        instr = 16'h0000;
        ext_enable = 1'b0;
        bank_select = 4'h0;
        mem_rdata = 8'h00;
        void'($urandom(91969));
        repeat (4) @(posedge clock);
        #2;
        srst = 1'b0;
        acc_m = 0;
        prod_m = 0;
        // Directed cases, back to back, with the documented worked values
        for (int i = 0; i < 12; i++) run_op(tab[i], tab_ext[i], 8'hB5);
        run_op(16'h0EFF, 1'b0, 8'h00);
        run_op(16'h0DFF, 1'b0, 8'h00);
        run_op(16'hFFFF, 1'b1, 8'h00);
        // Reset in mid-instruction restarts the cycle with zeroed results
        instr = 16'h0E77;
        @(posedge clock);
        #2;
        srst = 1'b1;
        @(posedge clock);
        #2;
        srst = 1'b0;
        acc_m = 0;
        prod_m = 0;
        check("phase after reset", 16'(phase), 16'(LMMX_Q1));
        check("acc after reset", 16'(acc), 16'h0000);
        check("req after reset", 16'(mem_req.rd | mem_req.wr | done), 16'h0000);
        // Random mix of the four instructions and unknown codes
        for (int i = 0; i < 200; i++) begin
            case ($urandom_range(0, 4))
                0: hi = LMMX_OP_LOAD_LIT;
                1: hi = LMMX_OP_MUL_LIT;
                2: hi = {LMMX_OP_STORE, 1'($urandom)};
                3: hi = {LMMX_OP_MUL_FILE, 1'($urandom)};
                default: hi = 8'($urandom);
            endcase
            run_op({hi, 8'($urandom)}, 1'($urandom), 8'($urandom));
        end
        tally_and_finish();
    end
endmodule
